// >>> hdl/agr_gate_reset_ctrl.sv
// Purpose: address-line-20 gate and keyboard reset control with fast port
// Assumes: AHB-Lite slave on REF_CLK; controller firmware levels on same clock
// Notes:   reads take one wait state, writes none; response always OKAY
//
// Our own choice: register access over AHB-Lite.
module agr_gate_reset_ctrl #(
   parameter int DELAY_CYC = agr_pkg::RST_DELAY_CYC,
   parameter int LOW_CYC   = agr_pkg::RST_LOW_CYC
) (
   // clock and reset
   input  wire logic                        REF_CLK,
   input  wire logic                        RST,
   // AHB-Lite slave
   input  wire logic                        HSEL,
   input  wire logic [agr_pkg::HADDR_W-1:0] HADDR,
   input  wire logic [1:0]                  HTRANS,
   input  wire logic                        HWRITE,
   input  wire logic [2:0]                  HSIZE,
   input  wire logic [31:0]                 HWDATA,
   input  wire logic                        HREADY,
   output logic      [31:0]                 HRDATA,
   output logic                             HREADYOUT,
   output logic                             HRESP,
   // software-driven controller levels
   input  wire logic                        SW_GATE,
   input  wire logic                        SW_RESET_N,
   // controlled outputs
   output logic                             ADDRESS_LINE20_GATE,
   output logic                             KEYBOARD_RESET_OUT_N,
   output logic      [1:0]                  CTRL_CLOCK_SEL
);

   ////////////////////////////////////////////////////////////////////////////
   // bus front end

   logic                          addr_phase;
   logic                          wr_pend_r;
   logic                          rd_pend_r;
   logic [agr_pkg::HADDR_W-1:0]   wr_addr_r;
   logic [agr_pkg::HADDR_W-1:0]   rd_addr_r;
   logic                          hreadyout_r;
   logic [31:0]                   hrdata_r;
   logic                          hresp_r;
   logic [7:0]                    wbyte;

   // HSIZE is not checked: only whole-word transfers are issued
   assign addr_phase = HSEL && (HTRANS == agr_pkg::HTRANS_NONSEQ) && HREADY;
   assign wbyte      = HWDATA[7:0];

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
      end else begin
         wr_pend_r <= addr_phase && HWRITE;
         if (addr_phase && HWRITE) begin
            wr_addr_r <= HADDR;
         end
      end
   end

   logic wr_cmd;
   logic wr_data;
   logic wr_fast;
   logic wr_cfg;

   // writes commit at the end of the data phase, which never waits
   assign wr_cmd  = wr_pend_r && (wr_addr_r == agr_pkg::reg_addr(agr_pkg::IDX_CMD));
   assign wr_data = wr_pend_r && (wr_addr_r == agr_pkg::reg_addr(agr_pkg::IDX_DATA));
   assign wr_fast = wr_pend_r && (wr_addr_r == agr_pkg::reg_addr(agr_pkg::IDX_FAST_PORT));
   assign wr_cfg  = wr_pend_r && (wr_addr_r == agr_pkg::reg_addr(agr_pkg::IDX_CFG));

   ////////////////////////////////////////////////////////////////////////////
   // configuration register

   logic [7:0] cfg_r;
   logic       fast_port_enable;
   logic       hw_gate_select;
   logic       hw_reset_select;
   logic       ctrl_clock_sel_hi;
   logic       ctrl_clock_sel_lo;

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         cfg_r <= agr_pkg::CFG_RESET;
      end else if (wr_cfg) begin
         // reserved bits 5:3 stay zero
         cfg_r <= wbyte & agr_pkg::CFG_WR_MASK;
      end
   end

   assign ctrl_clock_sel_hi = cfg_r[agr_pkg::CFG_CLKSEL_HI];
   assign ctrl_clock_sel_lo = cfg_r[agr_pkg::CFG_CLKSEL_LO];
   assign fast_port_enable  = cfg_r[agr_pkg::CFG_FAST_EN];
   assign hw_gate_select    = cfg_r[agr_pkg::CFG_HW_GATE];
   assign hw_reset_select   = cfg_r[agr_pkg::CFG_HW_RST];

   // the controller core derives its rate from this code
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         CTRL_CLOCK_SEL <= agr_pkg::CFG_RESET[agr_pkg::CFG_CLKSEL_HI:agr_pkg::CFG_CLKSEL_LO];
      end else begin
         CTRL_CLOCK_SEL <= {ctrl_clock_sel_hi, ctrl_clock_sel_lo};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // hardware command decoding

   logic [7:0] last_cmd_r;
   logic [7:0] last_data_r;
   logic       d1_pend_r;
   logic       hw_gate_r;
   logic       hw_rst_level_r;
   logic       cmd_trig;

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         last_cmd_r  <= '0;
         last_data_r <= '0;
      end else begin
         if (wr_cmd) begin
            last_cmd_r <= wbyte;
         end
         if (wr_data) begin
            last_data_r <= wbyte;
         end
      end
   end

   // any other command cancels a waiting D1 data byte
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         d1_pend_r <= 1'b0;
      end else if (wr_cmd) begin
         d1_pend_r <= (wbyte == agr_pkg::CMD_GATE_WRITE);
      end else if (wr_data) begin
         d1_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         hw_gate_r      <= 1'b0;
         hw_rst_level_r <= 1'b1;
      end else if (wr_data && d1_pend_r) begin
         hw_gate_r      <= wbyte[agr_pkg::D1_GATE_BIT];
         hw_rst_level_r <= wbyte[agr_pkg::D1_RESET_BIT];
      end
   end

   // the pulse command only acts when hardware owns the reset line
   assign cmd_trig = wr_cmd && (wbyte == agr_pkg::CMD_PULSE_RESET) && hw_reset_select;

   logic cmd_low;
   logic cmd_busy;

   agr_pulse_gen #(
      .DELAY_CYC (DELAY_CYC),
      .LOW_CYC   (LOW_CYC)
   ) u_cmd_pulse (
      .clk        (REF_CLK),
      .rst        (RST),
      .trig       (cmd_trig),
      .low_active (cmd_low),
      .busy       (cmd_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // fast control port

   logic [7:0] fast_r;
   logic       fast_gate_drive;
   logic       fast_reset_pulse;
   logic       fast_trig;
   logic       fast_low;
   logic       fast_busy;

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         fast_r <= agr_pkg::FP_RESET;
      end else if (wr_fast) begin
         fast_r <= (wbyte & agr_pkg::FP_WR_MASK) | agr_pkg::FP_FIXED_ONES;
      end
   end

   assign fast_gate_drive  = fast_r[agr_pkg::FP_GATE];
   assign fast_reset_pulse = fast_r[agr_pkg::FP_PULSE];

   // only a 0-to-1 change of the bit starts a pulse, so the host must
   // clear it between requests; a write while disabled starts nothing
   assign fast_trig = wr_fast && wbyte[agr_pkg::FP_PULSE] && !fast_reset_pulse
                      && fast_port_enable;

   agr_pulse_gen #(
      .DELAY_CYC (DELAY_CYC),
      .LOW_CYC   (LOW_CYC)
   ) u_fast_pulse (
      .clk        (REF_CLK),
      .rst        (RST),
      .trig       (fast_trig),
      .low_active (fast_low),
      .busy       (fast_busy)
   );

   ////////////////////////////////////////////////////////////////////////////
   // source selection and merge

   logic kbc_gate;
   logic kbc_reset_n;
   logic merged_gate;
   logic merged_reset_n;

   // one owner per line: firmware level or hardware logic
   assign kbc_gate    = hw_gate_select ? hw_gate_r : SW_GATE;
   assign kbc_reset_n = hw_reset_select ? (hw_rst_level_r && !cmd_low)
                                        : SW_RESET_N;

   // fast port contributes only while enabled
   assign merged_gate    = kbc_gate || (fast_port_enable && fast_gate_drive);
   assign merged_reset_n = kbc_reset_n && !(fast_port_enable && fast_low);

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ADDRESS_LINE20_GATE  <= 1'b0;
         KEYBOARD_RESET_OUT_N <= 1'b1;
      end else begin
         ADDRESS_LINE20_GATE  <= merged_gate;
         KEYBOARD_RESET_OUT_N <= merged_reset_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path

   logic [7:0] status_byte;
   logic [7:0] rd_byte;

   always_comb begin
      status_byte                       = '0;
      status_byte[agr_pkg::ST_GATE]     = ADDRESS_LINE20_GATE;
      status_byte[agr_pkg::ST_RESET_N]  = KEYBOARD_RESET_OUT_N;
      status_byte[agr_pkg::ST_CMD_BUSY] = cmd_busy;
      status_byte[agr_pkg::ST_FAST_BUSY] = fast_busy;
      status_byte[agr_pkg::ST_D1_PEND]  = d1_pend_r;
   end

   // unmapped addresses read as zero
   always_comb begin
      if (rd_addr_r == agr_pkg::reg_addr(agr_pkg::IDX_CMD)) begin
         rd_byte = last_cmd_r;
      end else if (rd_addr_r == agr_pkg::reg_addr(agr_pkg::IDX_DATA)) begin
         rd_byte = last_data_r;
      end else if (rd_addr_r == agr_pkg::reg_addr(agr_pkg::IDX_STATUS)) begin
         rd_byte = status_byte;
      end else if (rd_addr_r == agr_pkg::reg_addr(agr_pkg::IDX_FAST_PORT)) begin
         rd_byte = fast_r;
      end else if (rd_addr_r == agr_pkg::reg_addr(agr_pkg::IDX_CFG)) begin
         rd_byte = cfg_r;
      end else begin
         rd_byte = '0;
      end
   end

   // one wait state lets a write in the preceding data phase land first
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rd_pend_r   <= 1'b0;
         rd_addr_r   <= '0;
         hreadyout_r <= 1'b1;
         hrdata_r    <= '0;
         hresp_r     <= 1'b0;
      end else begin
         hresp_r <= 1'b0;
         if (addr_phase && !HWRITE) begin
            rd_pend_r   <= 1'b1;
            rd_addr_r   <= HADDR;
            hreadyout_r <= 1'b0;
         end else if (rd_pend_r) begin
            rd_pend_r   <= 1'b0;
            hreadyout_r <= 1'b1;
            hrdata_r    <= {24'h000000, rd_byte};
         end else begin
            hreadyout_r <= 1'b1;
         end
      end
   end

   assign HRDATA    = hrdata_r;
   assign HREADYOUT = hreadyout_r;
   assign HRESP     = hresp_r;

endmodule

// >>> shared/agr_pkg.sv
// Purpose: constants for the address-line-20 gate and keyboard reset control block
// Assumes: 20 MHz reference clock, 32-bit AHB-Lite register bus, word registers
// Notes:   register index times four gives the byte address on the bus
package agr_pkg;

   localparam int          HADDR_W         = 12;
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

   // register indices; byte address is index times four
   localparam logic [7:0]  IDX_CMD         = 8'h00;
   localparam logic [7:0]  IDX_DATA        = 8'h01;
   localparam logic [7:0]  IDX_STATUS      = 8'h02;
   localparam logic [7:0]  IDX_FAST_PORT   = 8'h92;
   localparam logic [7:0]  IDX_CFG         = 8'hF0;

   // configuration register
   localparam logic [7:0]  CFG_RESET       = 8'h80;
   localparam logic [7:0]  CFG_WR_MASK     = 8'hC7;
   localparam int          CFG_CLKSEL_HI   = 7;
   localparam int          CFG_CLKSEL_LO   = 6;
   localparam int          CFG_FAST_EN     = 2;
   localparam int          CFG_HW_GATE     = 1;
   localparam int          CFG_HW_RST      = 0;
   localparam logic [1:0]  CLKSEL_6MHZ     = 2'h0;
   localparam logic [1:0]  CLKSEL_8MHZ     = 2'h1;
   localparam logic [1:0]  CLKSEL_12MHZ    = 2'h2;
   localparam logic [1:0]  CLKSEL_16MHZ    = 2'h3;

   // fast control port
   localparam logic [7:0]  FP_RESET        = 8'h24;
   localparam logic [7:0]  FP_FIXED_ONES   = 8'h24;
   localparam logic [7:0]  FP_WR_MASK      = 8'h03;
   localparam int          FP_GATE         = 1;
   localparam int          FP_PULSE        = 0;

   // controller commands and data bits
   localparam logic [7:0]  CMD_GATE_WRITE  = 8'hD1;
   localparam logic [7:0]  CMD_PULSE_RESET = 8'hFE;
   localparam int          D1_GATE_BIT     = 1;
   localparam int          D1_RESET_BIT    = 0;

   // status register bits
   localparam int          ST_GATE         = 0;
   localparam int          ST_RESET_N      = 1;
   localparam int          ST_CMD_BUSY     = 2;
   localparam int          ST_FAST_BUSY    = 3;
   localparam int          ST_D1_PEND      = 4;

   // timing
   localparam int          REF_PERIOD_NS   = 50;
   localparam int          RST_DELAY_NS    = 14000;
   localparam int          RST_LOW_NS      = 6000;
   localparam int          RST_DELAY_CYC   = (RST_DELAY_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   localparam int          RST_LOW_CYC     = (RST_LOW_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   localparam int          CNT_W           = 16;

   function automatic logic [HADDR_W-1:0] reg_addr(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction

endpackage

// >>> hdl/agr_pulse_gen.sv
// Purpose: delayed low pulse for the keyboard reset line
// Assumes: trigger is a one-cycle pulse on the same clock
// Notes:   triggers arriving while a pulse is in progress are ignored
module agr_pulse_gen #(
   parameter int DELAY_CYC = agr_pkg::RST_DELAY_CYC,
   parameter int LOW_CYC   = agr_pkg::RST_LOW_CYC
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // request and state
   input  wire logic trig,
   output logic      low_active,
   output logic      busy
);

   typedef enum logic [2:0] {
      AGR_P_IDLE = 3'h1,
      AGR_P_WAIT = 3'h2,
      AGR_P_LOW  = 3'h4
   } agr_pstate_e;

   agr_pstate_e                     state_r;
   logic [agr_pkg::CNT_W-1:0]       cnt_r;

   localparam int                        CW         = agr_pkg::CNT_W;
   localparam logic [agr_pkg::CNT_W-1:0] DELAY_LAST = CW'(DELAY_CYC - 1);
   localparam logic [agr_pkg::CNT_W-1:0] LOW_LAST   = CW'(LOW_CYC - 1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= AGR_P_IDLE;
         cnt_r   <= '0;
      end else begin
         case (state_r)
            AGR_P_IDLE: begin
               cnt_r <= '0;
               if (trig) begin
                  state_r <= AGR_P_WAIT;
               end
            end
            AGR_P_WAIT: begin
               // at least the full delay passes before the line drops
               if (cnt_r == DELAY_LAST) begin
                  cnt_r   <= '0;
                  state_r <= AGR_P_LOW;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            AGR_P_LOW: begin
               if (cnt_r == LOW_LAST) begin
                  cnt_r   <= '0;
                  state_r <= AGR_P_IDLE;
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            default: begin
               cnt_r   <= '0;
               state_r <= AGR_P_IDLE;
            end
         endcase
      end
   end

   assign low_active = (state_r == AGR_P_LOW);
   assign busy       = (state_r != AGR_P_IDLE);

endmodule

// >>> bench/agr_gate_reset_ctrl_assertions.sv
// Purpose: bus timing and output checks for the gate and reset controller
// Assumes: writes finish with no wait state, reads with one
// Notes:   shadow copies of cfg and fast port give the output checks their context
module agr_gate_reset_ctrl_assertions #(
   parameter int DELAY_CYC = 4,
   parameter int LOW_CYC   = 3
) (
   // clock and reset
   input wire logic                        REF_CLK,
   input wire logic                        RST,
   // bus
   input wire logic                        HSEL,
   input wire logic [agr_pkg::HADDR_W-1:0] HADDR,
   input wire logic [1:0]                  HTRANS,
   input wire logic                        HWRITE,
   input wire logic [31:0]                 HWDATA,
   input wire logic                        HREADY,
   input wire logic                        HREADYOUT,
   // levels and outputs
   input wire logic                        SW_GATE,
   input wire logic                        SW_RESET_N,
   input wire logic                        ADDRESS_LINE20_GATE,
   input wire logic                        KEYBOARD_RESET_OUT_N,
   input wire logic [1:0]                  CTRL_CLOCK_SEL
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   ////////////////////////////////////////////////////////////////////////////////
   logic                        wr_r, up_r, armed_r;
   logic [agr_pkg::HADDR_W-1:0] a_r;
   logic [7:0]                  cfg_r, fp_r;
   logic [15:0]                 cnt_r;
   wire       take = HSEL && HTRANS == agr_pkg::HTRANS_NONSEQ && HREADY;
   wire [7:0] wd   = HWDATA[7:0];
   wire       wcfg = wr_r && HREADY && a_r == {2'h0, agr_pkg::IDX_CFG, 2'h0};
   wire       wfp  = wr_r && HREADY && a_r == {2'h0, agr_pkg::IDX_FAST_PORT, 2'h0};
   wire       wcmd = wr_r && HREADY && a_r == {2'h0, agr_pkg::IDX_CMD, 2'h0};
   wire       trig = (wfp && wd[0] && !fp_r[0] && cfg_r[2]) ||
                     (wcmd && wd == agr_pkg::CMD_PULSE_RESET && cfg_r[0]);
   wire       soft_g = !cfg_r[1] && !(cfg_r[2] && fp_r[1]);
   wire       soft_r = !cfg_r[0] && !cfg_r[2];
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         wr_r <= 1'b0;
         a_r  <= '0;
         up_r <= 1'b0;
      end else begin
         up_r <= 1'b1;
         if (HREADY) begin
            wr_r <= take && HWRITE;
            a_r  <= HADDR;
         end
      end
   end
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         cfg_r <= agr_pkg::CFG_RESET;
         fp_r  <= agr_pkg::FP_RESET;
      end else begin
         if (wcfg) cfg_r <= wd & agr_pkg::CFG_WR_MASK;
         if (wfp) fp_r <= (wd & agr_pkg::FP_WR_MASK) | agr_pkg::FP_FIXED_ONES;
      end
   end
   // armed from trigger until the reset line first drops
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         armed_r <= 1'b0;
         cnt_r   <= '0;
      end else if (!armed_r) begin
         armed_r <= trig;
         cnt_r   <= '0;
      end else begin
         if (!KEYBOARD_RESET_OUT_N) armed_r <= 1'b0;
         cnt_r <= cnt_r + 16'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence low_hold;
      !KEYBOARD_RESET_OUT_N [*3];
   endsequence
   chk_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read did not take exactly one wait state");
   chk_write_nowait: assert property (take && HWRITE |=> HREADYOUT)
      else $error("write stalled the bus");
   chk_clock_sel: assert property (wcfg |-> ##2 CTRL_CLOCK_SEL == $past(wd[7:6], 2))
      else $error("clock select does not follow cfg");
   chk_gate_soft: assert property (up_r && soft_g && $past(soft_g) |->
      ADDRESS_LINE20_GATE == $past(SW_GATE)) else $error("gate not from firmware level");
   chk_gate_merge: assert property (cfg_r[2] && fp_r[1] && $past(cfg_r[2] && fp_r[1])
      |-> ADDRESS_LINE20_GATE) else $error("fast port gate not merged");
   chk_reset_soft: assert property (up_r && soft_r && $past(soft_r) && !armed_r |->
      KEYBOARD_RESET_OUT_N == $past(SW_RESET_N)) else $error("reset not from firmware level");
   chk_pulse_early: assert property (armed_r && !KEYBOARD_RESET_OUT_N |->
      cnt_r >= DELAY_CYC) else $error("reset pulse came too early");
   chk_pulse_late: assert property (armed_r |-> cnt_r <= DELAY_CYC + 6)
      else $error("reset pulse never came");
   chk_pulse_width: assert property (armed_r && $fell(KEYBOARD_RESET_OUT_N) |-> low_hold)
      else $error("reset pulse too short");
endmodule

// >>> bench/agr_host_model.sv
// Purpose: host side bus master issuing single word transfers
// Assumes: one slave whose ready is the bus ready
// Notes:   released address and data lines show inverted values, not stale ones
module agr_host_model (
   // clock and answer
   input  wire logic                        clk,
   input  wire logic                        hready,
   input  wire logic [31:0]                 hrdata,
   // request
   output logic                             hsel,
   output logic      [agr_pkg::HADDR_W-1:0] haddr,
   output logic      [1:0]                  htrans,
   output logic                             hwrite,
   output logic      [2:0]                  hsize,
   output logic      [31:0]                 hwdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = '0;
   end
   // entered just after a rising edge, returns just after the data phase edge
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= agr_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {2'h0, idx, 2'h0};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~haddr;
      hwdata <= wr ? {24'h0, d} : ~hwdata;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      q = hrdata;
      hwdata <= ~hwdata;
   endtask
endmodule

// >>> bench/testbench.sv
// Purpose: register and output sequences for the gate and reset controller
// Assumes: short pulse counts so the run stays brief
// Notes:   outputs are read three edges after a cause to let the output stage land
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DLY = 4;
   localparam int LOWC = 3;
   logic REF_CLK, RST, SW_GATE, SW_RESET_N, HSEL, HWRITE, HREADYOUT, HRESP, gate, rst_n;
   logic [1:0] HTRANS, clk_sel;
   logic [2:0] HSIZE;
   logic [agr_pkg::HADDR_W-1:0] HADDR;
   logic [31:0] HWDATA, HRDATA, rv;
   int mismatches = 0;
   int tests_run = 0;
   agr_gate_reset_ctrl #(.DELAY_CYC(DLY), .LOW_CYC(LOWC)) agr_gate_reset_ctrl_i (
      .REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SW_GATE(SW_GATE), .SW_RESET_N(SW_RESET_N),
      .ADDRESS_LINE20_GATE(gate), .KEYBOARD_RESET_OUT_N(rst_n), .CTRL_CLOCK_SEL(clk_sel));
   agr_host_model agr_host_model_i (.clk(REF_CLK), .hready(HREADYOUT), .hrdata(HRDATA),
      .hsel(HSEL), .haddr(HADDR), .htrans(HTRANS), .hwrite(HWRITE), .hsize(HSIZE),
      .hwdata(HWDATA));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic w(input logic [7:0] i, input logic [7:0] d);
      agr_host_model_i.xfer(1'b1, i, d, rv);
   endtask
   task automatic rchk(input logic [7:0] i, input logic [31:0] exp);
      agr_host_model_i.xfer(1'b0, i, 8'h00, rv);
      chk(rv, exp);
   endtask
   task automatic settle;
      repeat (3) @(posedge REF_CLK);
   endtask
   // counts cycles before the reset line drops and how long it stays low
   task automatic pulse(input logic exp);
      int dly;
      int low;
      dly = 0;
      low = 0;
      for (int k = 0; k < DLY + LOWC + 12; k++) begin
         @(posedge REF_CLK);
         if (rst_n === 1'b0) low++;
         else if (low == 0) dly++;
      end
      if (exp) begin
         chk(32'(dly >= DLY), 32'h1);
         chk(32'(low >= LOWC), 32'h1);
      end else chk(32'(low), 32'h0);
   endtask
   task automatic end_of_test;
      if (mismatches == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      REF_CLK = 1'b0;
      forever #25 REF_CLK = ~REF_CLK;
   end
   initial begin
      repeat (20000) @(posedge REF_CLK);
      mismatches++;
      end_of_test;
   end
   initial begin
      RST = 1'b1;
      SW_GATE = 1'b0;
      SW_RESET_N = 1'b1;
      repeat (3) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      chk(32'(clk_sel), 32'h2);
      rchk(agr_pkg::IDX_CFG, 32'h80);
      rchk(agr_pkg::IDX_FAST_PORT, 32'h24);
      for (int i = 0; i < 4; i++) begin
         w(agr_pkg::IDX_CFG, 8'(i * 64));
         settle;
         chk(32'(clk_sel), 32'(i));
      end
      SW_GATE <= 1'b1;
      SW_RESET_N <= 1'b0;
      settle;
      chk(32'({gate, rst_n}), 32'h2);
      w(agr_pkg::IDX_CFG, 8'h03);
      // firmware levels held opposite so the hardware path must win
      for (int i = 0; i < 4; i++) begin
         w(agr_pkg::IDX_CMD, agr_pkg::CMD_GATE_WRITE);
         w(agr_pkg::IDX_DATA, 8'((i + 2) % 4));
         settle;
         chk(32'({gate, rst_n}), 32'((i + 2) % 4));
      end
      w(agr_pkg::IDX_CMD, agr_pkg::CMD_GATE_WRITE);
      w(agr_pkg::IDX_CMD, 8'h20);
      w(agr_pkg::IDX_DATA, 8'h03);
      settle;
      chk(32'(gate), 32'h0);
      SW_RESET_N <= 1'b1;
      SW_GATE <= 1'b0;
      w(agr_pkg::IDX_CMD, agr_pkg::CMD_PULSE_RESET);
      pulse(1'b1);
      w(agr_pkg::IDX_CFG, 8'h02);
      w(agr_pkg::IDX_CMD, agr_pkg::CMD_PULSE_RESET);
      pulse(1'b0);
      w(agr_pkg::IDX_CFG, 8'h04);
      w(agr_pkg::IDX_FAST_PORT, 8'h02);
      settle;
      chk(32'(gate), 32'h1);
      rchk(agr_pkg::IDX_FAST_PORT, 32'h26);
      SW_GATE <= 1'b1;
      w(agr_pkg::IDX_FAST_PORT, 8'h00);
      settle;
      chk(32'(gate), 32'h1);
      SW_GATE <= 1'b0;
      settle;
      chk(32'(gate), 32'h0);
      w(agr_pkg::IDX_FAST_PORT, 8'h01);
      pulse(1'b1);
      w(agr_pkg::IDX_FAST_PORT, 8'h01);
      pulse(1'b0);
      w(agr_pkg::IDX_FAST_PORT, 8'h00);
      w(agr_pkg::IDX_FAST_PORT, 8'h01);
      pulse(1'b1);
      w(agr_pkg::IDX_FAST_PORT, 8'h00);
      w(agr_pkg::IDX_CFG, 8'h00);
      w(agr_pkg::IDX_FAST_PORT, 8'h03);
      settle;
      chk(32'(gate), 32'h0);
      pulse(1'b0);
      w(agr_pkg::IDX_CFG, 8'hFF);
      rchk(agr_pkg::IDX_CFG, 32'hC7);
      w(agr_pkg::IDX_CFG, 8'h00);
      w(8'h55, 8'hFF);
      rchk(8'h55, 32'h0);
      chk(32'(HRESP), 32'h0);
      // a mid-run reset must restore every default, fast port included
      RST <= 1'b1;
      repeat (3) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      rchk(agr_pkg::IDX_FAST_PORT, 32'h24);
      rchk(agr_pkg::IDX_CFG, 32'h80);
      rchk(agr_pkg::IDX_STATUS, 32'h02);
      chk(32'({gate, rst_n, clk_sel}), 32'h6);
      end_of_test;
   end
endmodule

bind agr_gate_reset_ctrl agr_gate_reset_ctrl_assertions #(
   .DELAY_CYC(DELAY_CYC), .LOW_CYC(LOW_CYC)) agr_chk_i (
   .REF_CLK(REF_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
   .SW_GATE(SW_GATE), .SW_RESET_N(SW_RESET_N), .ADDRESS_LINE20_GATE(ADDRESS_LINE20_GATE),
   .KEYBOARD_RESET_OUT_N(KEYBOARD_RESET_OUT_N), .CTRL_CLOCK_SEL(CTRL_CLOCK_SEL));
